// >>> hdl/sfx_flash_cmd.sv
// Purpose: serial flash instruction engine for fast reads, program, 4 KB clear
// Assumes: SCLK, CS_N and IO_IN synchronous to CORE_CLK, SCLK well below it
// Notes:   array access goes through the MEM_* ports; status layout lives outside
`timescale 1ns/1ps
module sfx_flash_cmd
   import sfx_pkg::*;
#(
   parameter int PROG_CYC  = PROG_CYCLES,
   parameter int CLEAR_CYC = CLEAR_CYCLES
)(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        SCLK,
   input  wire logic        CS_N,
   input  wire logic [3:0]  IO_IN,
   output logic [3:0]       IO_OUT,
   output logic [3:0]       IO_OE,
   output logic [23:0]      MEM_RD_ADDR,
   input  wire logic [7:0]  MEM_RD_DATA,
   output logic             MEM_WR_EN,
   output logic [23:0]      MEM_WR_ADDR,
   output logic [7:0]       MEM_WR_DATA,
   output logic             MEM_CLEAR,
   output logic [23:0]      MEM_CLEAR_ADDR,
   input  wire logic        WRITE_ENABLE_SET,
   input  wire logic        STATUS_WRITE_BUSY,
   input  wire logic [3:0]  BLOCK_PROTECT_BITS,
   input  wire logic        PROTECT_HOLD_PIN_DISABLE,
   output logic             WRITE_IN_PROGRESS,
   output logic             WRITE_ENABLE_LATCH,
   output logic             EXECUTE_IN_PLACE
);

   sfx_state_t        state;
   logic              sclk_d;
   logic              cs_d;
   logic [7:0]        cmd;
   logic [2:0]        lanes;
   logic [5:0]        cnt;
   logic [5:0]        dlen;
   logic [23:0]       sh;
   logic [23:0]       next_sh;
   logic [23:0]       addr;
   logic [23:0]       next_addr;
   logic [7:0]        opc_now;
   logic [3:0]        bcnt;
   logic [3:0]        next_bcnt;
   logic [7:0]        col;
   logic              got_byte;
   logic              mode_seen;
   logic              xip_pend;
   logic [7:0]        out_sh;
   logic [3:0]        out_cnt;
   logic [7:0]        out_src;
   logic              walk;
   logic [8:0]        widx;
   logic [15:0]       wpage;
   logic [TIMER_W-1:0] timer;
   logic              rise;
   logic              fall;
   logic              cs_rise;
   logic              busy_now;
   logic              prot;
   logic              start_prog;
   logic              start_clear;
   logic              pb_clear;
   logic              pb_wr;
   logic [7:0]        pb_rd_data;
   logic              pb_rd_valid;

   // edge detection of the sampled serial clock and chip select
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end else begin
         sclk_d <= SCLK;
         cs_d   <= CS_N;
      end
   end

   assign rise     = SCLK & ~sclk_d & ~CS_N;
   assign fall     = ~SCLK & sclk_d & ~CS_N;
   assign cs_rise  = CS_N & ~cs_d;
   assign busy_now = walk | (timer != '0) | STATUS_WRITE_BUSY;
   assign opc_now  = {sh[6:0], IO_IN[0]};

   // shift in by the current lane count; upper lanes carry high bits
   always_comb begin
      case (lanes)
         LANES_2: next_sh = {sh[21:0], IO_IN[1:0]};
         LANES_4: next_sh = {sh[19:0], IO_IN[3:0]};
         default: next_sh = {sh[22:0], IO_IN[0]};
      endcase
      next_bcnt = bcnt + {1'b0, lanes};
      next_addr = (addr == MEM_TOP) ? 24'h000000 : addr + 24'h000001;
   end

   sfx_protect u_protect (
      .addr (addr),
      .bp   (BLOCK_PROTECT_BITS),
      .prot (prot)
   );

   assign start_prog  = cs_rise && state == ST_PROG_IN && bcnt == 4'h0 && got_byte && !prot;
   assign start_clear = cs_rise && state == ST_CLEAR_ARM && !prot;
   assign pb_wr       = rise && state == ST_PROG_IN && next_bcnt == BYTE_BITS;
   // buffer kept while a walk runs
   assign pb_clear    = rise && state == ST_OPCODE && cnt == OPC_CLKS - 6'h01 && !busy_now;

   // frame sequencer: opcode, address, mode, dummy and data phases
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state     <= ST_IDLE;
         cmd       <= 8'h00;
         lanes     <= LANES_1;
         cnt       <= 6'h00;
         dlen      <= 6'h00;
         sh        <= 24'h000000;
         addr      <= 24'h000000;
         bcnt      <= 4'h0;
         col       <= 8'h00;
         got_byte  <= 1'b0;
         mode_seen <= 1'b0;
         xip_pend  <= 1'b0;
      end else if (CS_N) begin
         state     <= ST_IDLE;
         cnt       <= 6'h00;
         mode_seen <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               cnt      <= 6'h00;
               bcnt     <= 4'h0;
               got_byte <= 1'b0;
               if (EXECUTE_IN_PLACE) begin
                  cmd   <= OPC_QUAD_IO_READ;
                  lanes <= LANES_4;
                  state <= busy_now ? ST_IGNORE : ST_ADDR;
               end else begin
                  lanes <= LANES_1;
                  state <= ST_OPCODE;
               end
            end
            ST_OPCODE: if (rise) begin
               sh  <= next_sh;
               cnt <= cnt + 6'h01;
               if (cnt == OPC_CLKS - 6'h01) begin
                  cmd   <= opc_now;
                  cnt   <= 6'h00;
                  lanes <= LANES_1;
                  state <= ST_IGNORE;
                  case (opc_now)
                     OPC_DUAL_IO_READ: if (!busy_now) begin
                        lanes <= LANES_2;
                        state <= ST_ADDR;
                     end
                     OPC_QUAD_OUT_READ: if (!busy_now) begin
                        state <= ST_ADDR;
                     end
                     OPC_QUAD_IO_READ: if (!busy_now) begin
                        lanes <= LANES_4;
                        state <= ST_ADDR;
                     end
                     OPC_PAGE_PROGRAM: if (!busy_now && WRITE_ENABLE_LATCH) begin
                        state <= ST_ADDR;
                     end
                     OPC_QUAD_PAGE_PROG: begin
                        if (!busy_now && WRITE_ENABLE_LATCH && PROTECT_HOLD_PIN_DISABLE) begin
                           state <= ST_ADDR;
                        end
                     end
                     OPC_BLOCK4K_CLEAR: if (!busy_now && WRITE_ENABLE_LATCH) begin
                        state <= ST_ADDR;
                     end
                     default: state <= ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR: if (rise) begin
               sh  <= next_sh;
               cnt <= cnt + 6'h01;
               if ((lanes == LANES_1 && cnt == ADDR_CLKS_1 - 6'h01) ||
                   (lanes == LANES_2 && cnt == ADDR_CLKS_2 - 6'h01) ||
                   (lanes == LANES_4 && cnt == ADDR_CLKS_4 - 6'h01)) begin
                  addr <= next_sh;
                  col  <= next_sh[7:0];
                  cnt  <= 6'h00;
                  case (cmd)
                     OPC_QUAD_IO_READ: state <= ST_MODE;
                     OPC_DUAL_IO_READ: begin
                        dlen  <= DUMMY_DIO;
                        state <= ST_DUMMY;
                     end
                     OPC_QUAD_OUT_READ: begin
                        dlen  <= DUMMY_QOUT;
                        lanes <= LANES_4;
                        state <= ST_DUMMY;
                     end
                     OPC_PAGE_PROGRAM: state <= ST_PROG_IN;
                     OPC_QUAD_PAGE_PROG: begin
                        lanes <= LANES_4;
                        state <= ST_PROG_IN;
                     end
                     OPC_BLOCK4K_CLEAR: state <= ST_CLEAR_ARM;
                     default: state <= ST_IGNORE;
                  endcase
               end
            end
            ST_MODE: if (rise) begin
               sh  <= next_sh;
               cnt <= cnt + 6'h01;
               if (cnt == MODE_CLKS - 6'h01) begin
                  xip_pend  <= (next_sh[7:4] == ~next_sh[3:0]);
                  mode_seen <= 1'b1;
                  dlen      <= DUMMY_QIO;
                  cnt       <= 6'h00;
                  state     <= ST_DUMMY;
               end
            end
            ST_DUMMY: if (rise) begin
               cnt <= cnt + 6'h01;
               if (cnt == dlen - 6'h01) begin
                  state <= ST_READ_OUT;
               end
            end
            ST_READ_OUT: if (fall && out_cnt == 4'h0) begin
               addr <= next_addr;
            end
            ST_PROG_IN: if (rise) begin
               sh <= next_sh;
               if (next_bcnt == BYTE_BITS) begin
                  bcnt     <= 4'h0;
                  got_byte <= 1'b1;
                  col      <= col + 8'h01;
               end else begin
                  bcnt <= next_bcnt;
               end
            end
            // any later clock spoils the clear
            ST_CLEAR_ARM: if (rise) begin
               state <= ST_IGNORE;
            end
            ST_IGNORE: state <= ST_IGNORE;
            default:   state <= ST_IGNORE;
         endcase
      end
   end

   assign MEM_RD_ADDR = addr;
   assign out_src     = (out_cnt == 4'h0) ? MEM_RD_DATA : out_sh;

   // read data drivers; lanes released the cycle after deselect
   always_ff @(posedge CORE_CLK) begin
      if (RST || CS_N) begin
         IO_OUT  <= 4'h0;
         IO_OE   <= 4'h0;
         out_sh  <= 8'h00;
         out_cnt <= 4'h0;
      end else if (fall && state == ST_READ_OUT) begin
         if (lanes == LANES_2) begin
            IO_OUT <= {2'b00, out_src[7:6]};
            IO_OE  <= 4'h3;
            out_sh <= {out_src[5:0], 2'b00};
         end else begin
            IO_OUT <= out_src[7:4];
            IO_OE  <= 4'hf;
            out_sh <= {out_src[3:0], 4'h0};
         end
         out_cnt <= ((out_cnt == 4'h0) ? BYTE_BITS : out_cnt) - {1'b0, lanes};
      end
   end

   // continuous-read flag is decided only at deselect
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         EXECUTE_IN_PLACE <= 1'b0;
      end else if (cs_rise && mode_seen) begin
         EXECUTE_IN_PLACE <= xip_pend;
      end
   end

   // last 256 bytes kept by overwrite
   sfx_page_buf u_page_buf (
      .clk      (CORE_CLK),
      .rst      (RST),
      .clear    (pb_clear),
      .wr_en    (pb_wr),
      .wr_idx   (col),
      .wr_data  (next_sh[7:0]),
      .rd_idx   (widx[7:0]),
      .rd_data  (pb_rd_data),
      .rd_valid (pb_rd_valid)
   );

   // self-timed cycle: page walk or clear pulse to the array, then busy timer
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         walk           <= 1'b0;
         widx           <= 9'h000;
         wpage          <= 16'h0000;
         timer          <= '0;
         MEM_WR_EN      <= 1'b0;
         MEM_WR_ADDR    <= 24'h000000;
         MEM_WR_DATA    <= 8'h00;
         MEM_CLEAR      <= 1'b0;
         MEM_CLEAR_ADDR <= 24'h000000;
      end else begin
         MEM_WR_EN <= 1'b0;
         MEM_CLEAR <= 1'b0;
         if (start_prog) begin
            walk  <= 1'b1;
            widx  <= 9'h000;
            wpage <= addr[PAGE_HI:PAGE_LO];
         end else if (start_clear) begin
            MEM_CLEAR      <= 1'b1;
            MEM_CLEAR_ADDR <= addr & SECTOR_MASK;
            timer          <= TIMER_W'(CLEAR_CYC);
         end else if (walk) begin
            MEM_WR_EN   <= pb_rd_valid;
            MEM_WR_ADDR <= {wpage, widx[7:0]};
            MEM_WR_DATA <= pb_rd_data;
            widx        <= widx + 9'h001;
            if (widx == PAGE_LAST) begin
               walk  <= 1'b0;
               timer <= TIMER_W'(PROG_CYC);
            end
         end else if (timer != '0) begin
            timer <= timer - 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         WRITE_IN_PROGRESS <= 1'b0;
      end else begin
         WRITE_IN_PROGRESS <= busy_now | start_prog | start_clear;
      end
   end

   // latch set by an outside enable command; a set in the same cycle wins
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         WRITE_ENABLE_LATCH <= 1'b0;
      end else if (WRITE_ENABLE_SET) begin
         WRITE_ENABLE_LATCH <= 1'b1;
      end else if (start_prog || start_clear) begin
         WRITE_ENABLE_LATCH <= 1'b0;
      end
   end

endmodule

// >>> include/sfx_pkg.sv
// Purpose: shared constants and types for the serial flash command block
// Assumes: 24-bit addressing, 256 KB array, 40 MHz core clock
// Notes:   array sizes, opcodes, phase lengths and self-timed cycle counts
package sfx_pkg;

   // instruction codes seen on lane zero
   localparam logic [7:0]  OPC_DUAL_IO_READ   = 8'hbb;
   localparam logic [7:0]  OPC_QUAD_OUT_READ  = 8'h6b;
   localparam logic [7:0]  OPC_QUAD_IO_READ   = 8'heb;
   localparam logic [7:0]  OPC_PAGE_PROGRAM   = 8'h02;
   localparam logic [7:0]  OPC_QUAD_PAGE_PROG = 8'h32;
   localparam logic [7:0]  OPC_BLOCK4K_CLEAR  = 8'h20;

   // array geometry
   localparam int          ADDR_W       = 24;
   localparam logic [23:0] MEM_TOP      = 24'h03ffff;
   localparam logic [23:0] SECTOR_MASK  = 24'hfff000;
   localparam int          PAGE_HI      = 23;
   localparam int          PAGE_LO      = 8;
   localparam int          BLOCK_HI     = 17;
   localparam int          BLOCK_LO     = 16;
   localparam logic [2:0]  BLOCK_COUNT  = 3'h4;
   localparam logic [3:0]  BP_ALL       = 4'h4;
   localparam logic [8:0]  PAGE_LAST    = 9'h0ff;

   // lane widths and phase lengths in serial clocks
   localparam logic [2:0]  LANES_1      = 3'h1;
   localparam logic [2:0]  LANES_2      = 3'h2;
   localparam logic [2:0]  LANES_4      = 3'h4;
   localparam logic [5:0]  OPC_CLKS     = 6'h08;
   localparam logic [5:0]  ADDR_CLKS_1  = 6'h18;
   localparam logic [5:0]  ADDR_CLKS_2  = 6'h0c;
   localparam logic [5:0]  ADDR_CLKS_4  = 6'h06;
   localparam logic [5:0]  MODE_CLKS    = 6'h02;
   localparam logic [5:0]  DUMMY_QOUT   = 6'h08;
   localparam logic [5:0]  DUMMY_QIO    = 6'h04;
   localparam logic [5:0]  DUMMY_DIO    = 6'h04;
   localparam logic [3:0]  BYTE_BITS    = 4'h8;

   // self-timed cycle lengths
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          PROG_TIME_NS  = 200000;
   localparam int          CLEAR_TIME_NS = 1000000;
   localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int          CLEAR_CYCLES  = CLEAR_TIME_NS / CLK_PERIOD_NS;
   localparam int          TIMER_W       = 20;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_READ_OUT,
      ST_PROG_IN,
      ST_CLEAR_ARM,
      ST_IGNORE
   } sfx_state_t;

endpackage

// >>> hdl/sfx_protect.sv
// Purpose: decides whether an address lies in the protected area
// Assumes: block_protect_bits select upper 64 KB blocks
// Notes:   zero protects nothing, four or more protects everything
`timescale 1ns/1ps
module sfx_protect
   import sfx_pkg::*;
(
   input  wire logic [23:0] addr,
   input  wire logic [3:0]  bp,
   output logic             prot
);

   logic [2:0] first_blk;

   // protected blocks grow downward from the top of the array
   always_comb begin
      first_blk = BLOCK_COUNT - bp[2:0];
      if (bp == 4'h0) begin
         prot = 1'b0;
      end else if (bp >= BP_ALL) begin
         prot = 1'b1;
      end else begin
         prot = ({1'b0, addr[BLOCK_HI:BLOCK_LO]} >= first_blk);
      end
   end

endmodule

// >>> hdl/sfx_page_buf.sv
// Purpose: one page of program data held in flip-flops
// Assumes: cleared before each page program frame
// Notes:   a valid bit per byte marks which page bytes get programmed
`timescale 1ns/1ps
module sfx_page_buf
   import sfx_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_idx,
   input  wire logic [7:0] wr_data,
   input  wire logic [7:0] rd_idx,
   output logic [7:0]      rd_data,
   output logic            rd_valid
);

   logic [7:0] mem   [256];
   logic       valid [256];

   // per-entry storage; a later byte at the same index overwrites
   for (genvar g = 0; g < 256; g++) begin : g_entry
      always_ff @(posedge clk) begin
         if (rst || clear) begin
            valid[g] <= 1'b0;
         end else if (wr_en && wr_idx == 8'(g)) begin
            valid[g] <= 1'b1;
         end
      end
      always_ff @(posedge clk) begin
         if (wr_en && wr_idx == 8'(g)) begin
            mem[g] <= wr_data;
         end
      end
   end

   // indexed read for the program walk
   assign rd_data  = mem[rd_idx];
   assign rd_valid = valid[rd_idx];

endmodule

// >>> tb/sfx_flash_cmd_assertions.sv
// Purpose: port properties of the flash command block
// Assumes: one clock domain, reset high
// Notes:   cycle lengths arrive as the design's parameters
`timescale 1ns/1ps
module sfx_flash_cmd_chk
   import sfx_pkg::*;
#(
   parameter int PROG_CYC  = PROG_CYCLES,
   parameter int CLEAR_CYC = CLEAR_CYCLES
)(
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        CS_N,
   input wire logic [3:0]  IO_OE,
   input wire logic        MEM_WR_EN,
   input wire logic        MEM_CLEAR,
   input wire logic [23:0] MEM_CLEAR_ADDR,
   input wire logic        STATUS_WRITE_BUSY,
   input wire logic        WRITE_IN_PROGRESS,
   input wire logic        WRITE_ENABLE_LATCH,
   input wire logic        EXECUTE_IN_PLACE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   // lane enables, release and busy
   property p_oe_lanes;
      IO_OE != 4'h0 |-> IO_OE == 4'h3 || IO_OE == 4'hf;
   endproperty
   property p_oe_off;
      CS_N [*3] |-> IO_OE == 4'h0;
   endproperty
   property p_no_rd_busy;
      WRITE_IN_PROGRESS |-> IO_OE == 4'h0;
   endproperty
   // self-timed cycles
   property p_clear_base;
      MEM_CLEAR |-> MEM_CLEAR_ADDR[11:0] == 12'h000 && WRITE_IN_PROGRESS;
   endproperty
   property p_clear_pulse;
      MEM_CLEAR |=> !MEM_CLEAR;
   endproperty
   property p_wip_start;
      $rose(WRITE_IN_PROGRESS) && !STATUS_WRITE_BUSY |-> CS_N && !WRITE_ENABLE_LATCH;
   endproperty
   property p_wr_busy;
      MEM_WR_EN |-> WRITE_IN_PROGRESS && CS_N;
   endproperty
   property p_busy_len;
      $rose(WRITE_IN_PROGRESS) |-> WRITE_IN_PROGRESS [*8];
   endproperty
   // mode flag moves only while deselected
   property p_xip_cs;
      $changed(EXECUTE_IN_PLACE) |-> CS_N;
   endproperty
   a_oe_lanes: assert property (p_oe_lanes) else $error("bad lane set");
   a_oe_off: assert property (p_oe_off) else $error("lanes kept");
   a_no_rd_busy: assert property (p_no_rd_busy) else $error("read while busy");
   a_clear_base: assert property (p_clear_base) else $error("bad clear");
   a_clear_pulse: assert property (p_clear_pulse) else $error("long clear");
   a_wip_start: assert property (p_wip_start) else $error("bad start");
   a_wr_busy: assert property (p_wr_busy) else $error("write idle");
   a_busy_len: assert property (p_busy_len) else $error("short busy");
   a_xip_cs: assert property (p_xip_cs) else $error("flag in frame");
   c_clear: cover property (MEM_CLEAR);
   c_write: cover property (MEM_WR_EN);
   c_xip: cover property ($rose(EXECUTE_IN_PLACE));
endmodule
bind sfx_flash_cmd sfx_flash_cmd_chk #(
   .PROG_CYC           (PROG_CYC),
   .CLEAR_CYC          (CLEAR_CYC)
) u_chk (
   .CORE_CLK           (CORE_CLK),
   .RST                (RST),
   .CS_N               (CS_N),
   .IO_OE              (IO_OE),
   .MEM_WR_EN          (MEM_WR_EN),
   .MEM_CLEAR          (MEM_CLEAR),
   .MEM_CLEAR_ADDR     (MEM_CLEAR_ADDR),
   .STATUS_WRITE_BUSY  (STATUS_WRITE_BUSY),
   .WRITE_IN_PROGRESS  (WRITE_IN_PROGRESS),
   .WRITE_ENABLE_LATCH (WRITE_ENABLE_LATCH),
   .EXECUTE_IN_PLACE   (EXECUTE_IN_PLACE)
);

// >>> tb/sfx_host_model.sv
// Purpose: host end of the serial link
// Assumes: serial half period of three core cycles
// Notes:   host lanes toggle when idle; undriven device lanes read inverted
`timescale 1ns/1ps
module sfx_host_model (
   input  wire logic       clk,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe,
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      io_in
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_in = 4'hf;
   end
   // idle cycle before the first rise
   task automatic sel;
      @(posedge clk);
      #1;
      cs_n = 1'b0;
   endtask
   task automatic desel;
      repeat (2) @(posedge clk);
      #1;
      cs_n = 1'b1;
      io_in = ~io_in;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input int w, input logic [31:0] v, input int n, input bit rd,
                       output logic [31:0] q);
      logic [3:0] b;
      q = '0;
      for (int i = 0; i < n; i += w) begin
         b = 4'((v >> (n - i - w)) & ((1 << w) - 1));
         io_in = rd ? ~io_in : w == 4 ? b : w == 2 ? {2'b11, b[1:0]} : {3'b111, b[0]};
         repeat (3) @(posedge clk);
         #1;
         // released lanes show the inverse of the last value
         q = (q << w) | 32'(~(io_out ^ io_oe) & 4'((1 << w) - 1));
         sclk = 1'b1;
         repeat (3) @(posedge clk);
         #1;
         sclk = 1'b0;
      end
   endtask
endmodule

// >>> tb/sfx_flash_cmd_bench.sv
// Purpose: self-checking bench for the flash command block
// Assumes: short self-timed cycles set by parameter
// Notes:   array model returns low address byte xor 5a
`timescale 1ns/1ps
module sfx_flash_cmd_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wen_set = 1'b0;
   logic [3:0]  bp = 4'h0;
   logic        phpd = 1'b0;
   logic        swb = 1'b0;
   logic        sclk, cs_n, mwe, mclr, write_in_progress, write_enable_latch, execute_in_place;
   logic [3:0]  io_in, io_out, io_oe;
   logic [3:0]  seen_oe = 4'h0;
   logic [23:0] mra, mwa, mca, ca, wa[$];
   logic [7:0]  mwd, wd[$];
   logic [7:0]  modes[8] = '{8'ha5, 8'h5a, 8'hf0, 8'h0f, 8'hff, 8'h00, 8'haa, 8'h55};
   logic [31:0] q;
   int          err_count = 0;
   int          samples_checked = 0;
   int          nc = 0;
   bit          x = 0;
   always #12.5 clk = ~clk;
   sfx_host_model h (.clk(clk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n),
                     .io_in(io_in));
   sfx_flash_cmd #(.PROG_CYC(20), .CLEAR_CYC(400)) uut (
      .CORE_CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE(io_oe), .MEM_RD_ADDR(mra), .MEM_RD_DATA(mra[7:0] ^ 8'h5a),
      .MEM_WR_EN(mwe), .MEM_WR_ADDR(mwa), .MEM_WR_DATA(mwd), .MEM_CLEAR(mclr),
      .MEM_CLEAR_ADDR(mca), .WRITE_ENABLE_SET(wen_set), .STATUS_WRITE_BUSY(swb),
      .BLOCK_PROTECT_BITS(bp), .PROTECT_HOLD_PIN_DISABLE(phpd),
      .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .EXECUTE_IN_PLACE(execute_in_place));
   // array side log: writes, clears, any lane drive
   always @(posedge clk) begin
      seen_oe |= io_oe;
      if (mwe === 1'b1) begin
         wa.push_back(mwa);
         wd.push_back(mwd);
      end
      if (mclr === 1'b1) begin
         nc++;
         ca = mca;
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // bounded wait for the busy flag to drop
   task automatic wbusy;
      for (int i = 0; i < 1000 && write_in_progress !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      if (write_in_progress !== 1'b0) begin
         chk("busy end", 32'h0, 32'(write_in_progress));
         summarize();
      end
   endtask
   task automatic wen;
      wen_set = 1'b1;
      @(posedge clk);
      #1;
      wen_set = 1'b0;
   endtask
   // read frame; opcode 00 means skipped
   task automatic rd(input logic [7:0] c, input int aw, input logic [23:0] a,
                     input logic [7:0] m, input int mn, input int dn, input int rw, input int nd);
      h.sel();
      if (c !== 8'h00)
         h.xfer(1, c, 8, 0, q);
      h.xfer(aw, a, 24, 0, q);
      h.xfer(aw, m, mn, 0, q);
      h.xfer(aw, 0, dn, 1, q);
      h.xfer(rw, 0, nd, 1, q);
      h.desel();
   endtask
   // program or clear frame; ex adds stray bits
   task automatic pg(input logic [7:0] c, input logic [23:0] a, input int w, input int nb,
                     input int ex);
      wa.delete();
      wd.delete();
      h.sel();
      h.xfer(1, c, 8, 0, q);
      h.xfer(1, a, 24, 0, q);
      for (int k = 0; k < nb; k++)
         h.xfer(w, 8'(k + k / 256 * 64 + 17), 8, 0, q);
      h.xfer(w, 0, ex, 0, q);
      h.desel();
      wbusy();
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rd(8'hbb, 2, 24'h03fffe, 0, 0, 8, 2, 24);
      chk("dual rd", 32'ha4a55a, q);
      rd(8'h6b, 1, 24'h000010, 0, 0, 8, 4, 16);
      chk("quad out rd", 32'h4a4b, q);
      $display("reads done");
      foreach (modes[i]) begin
         rd(x ? 8'h00 : 8'heb, 4, 24'h20 + 24'(i), modes[i], 8, 16, 4, 8);
         chk("quad io rd", 32'(8'h7a ^ 8'(i)), q);
         x = modes[i][7:4] == ~modes[i][3:0];
         chk("xip flag", 32'(x), 32'(execute_in_place));
      end
      rd(8'heb, 4, 24'h000040, 8'hff, 8, 16, 4, 4);
      chk("abort nibble", 32'h1, q);
      chk("abort oe", 32'h0, 32'(io_oe));
      $display("continuous done");
      pg(8'h02, 24'h000100, 1, 1, 0);
      chk("no latch", 32'h0, wa.size());
      wen();
      pg(8'h02, 24'h0001fe, 1, 3, 0);
      chk("wr count", 32'h3, wa.size());
      chk("wrap wr", 32'h00010013, {wa[0], wd[0]});
      chk("first wr", 32'h0001fe11, {wa[1], wd[1]});
      wen();
      pg(8'h02, 24'h000200, 1, 1, 4);
      chk("partial", 32'h0, wa.size());
      bp = 4'h1;
      pg(8'h02, 24'h030000, 1, 1, 0);
      chk("prot page", 32'h0, wa.size());
      bp = 4'h0;
      wen();
      pg(8'h32, 24'h000000, 4, 1, 0);
      chk("quad no pin bit", 32'h0, wa.size());
      phpd = 1'b1;
      pg(8'h32, 24'h000000, 4, 258, 0);
      chk("quad count", 32'd256, wa.size());
      chk("last kept", 32'h51, wd[0]);
      chk("quad data", 32'h13, wd[2]);
      $display("program done");
      wen();
      h.sel();
      h.xfer(1, 32'h20012345, 32, 0, q);
      h.desel();
      chk("busy", 32'h1, 32'(write_in_progress));
      chk("latch off", 32'h0, 32'(write_enable_latch));
      seen_oe = 4'h0;
      rd(8'heb, 4, 24'h0, 8'hff, 8, 16, 4, 8);
      chk("rd busy", 32'h0, 32'(seen_oe));
      chk("rd busy lanes", 32'hff, q);
      wbusy();
      chk("clr base", 32'h012000, ca);
      wen();
      pg(8'h20, 24'h0, 1, 0, 1);
      bp = 4'h4;
      pg(8'h20, 24'h0, 1, 0, 0);
      chk("clr count", 32'h1, nc);
      $display("clear done");
      swb = 1'b1;
      seen_oe = 4'h0;
      rd(8'heb, 4, 24'h0, 8'hff, 8, 16, 4, 8);
      chk("status busy", 32'h1, 32'(write_in_progress));
      chk("rd status busy", 32'h0, 32'(seen_oe));
      swb = 1'b0;
      wbusy();
      $display("status busy done");
      summarize();
   end
endmodule
